//--- tpos_output_stage.sv
// Purpose: three-phase pwm output stage with crossover, disable, chop, trip
// Assumes: apb slave, 10 MHz clk, trip pin active low and asynchronous
// Notes:   gate outputs are flops; trip forces them low asynchronously
`timescale 1ns/1ps
`default_nettype none
`include "tpos_consts.svh"
module tpos_output_stage
  import tpos_pkg::*;
#(
  parameter int ADDR_W = `TPOS_ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire tpos_gates_t       timingGates,
  input  wire logic              cycleSyncIn,
  input  wire logic              faultTripN,
  output var  tpos_gates_t       gateOut,
  output var  logic              cycleSyncPulse,
  output var  logic              tripIrq,
  output var  logic              syncFiq,
  output var  logic              timingRun
);
  // registers
  logic [8:0]  outputEnableCrossover_reg;
  logic [8:0]  outenShadow_reg;
  logic [15:0] gateChopConfig_reg;
  logic [15:0] periodRegister_reg;
  logic [15:0] dutyPhase0_reg;
  logic [15:0] dutyPhase1_reg;
  logic [15:0] dutyPhase2_reg;
  logic [7:0]  mainControl_reg;
  logic        tripIrqFlag_reg;
  logic        syncIrqFlag_reg;
  logic [3:0]  reloadSeen_reg;
  logic        timingRun_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        syncPrev_reg;
  logic        syncOut_reg;
  logic        tripIrq_reg;
  logic        syncFiq_reg;
  logic [2:0]  tripSync_reg;
  logic        tripLevel_reg;
  tpos_gates_t gateOut_reg;

  // trip pin: three-flop sampler for status and events
  wire tripStable = (tripSync_reg[1] == tripSync_reg[2]);
  wire tripLow    = ~tripLevel_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tripSync_reg  <= 3'b000;
      tripLevel_reg <= 1'b0;
    end else begin
      tripSync_reg  <= {tripSync_reg[1:0], faultTripN};
      if (tripStable) begin
        tripLevel_reg <= tripSync_reg[2];
      end
    end
  end
  // enter trip when the filtered level falls
  wire tripEntered;
  logic tripLevelPrev_reg;
  assign tripEntered = tripLevelPrev_reg & tripLow;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tripLevelPrev_reg <= 1'b0;
    end else begin
      tripLevelPrev_reg <= tripLevel_reg;
    end
  end

  // apb decode: one-wait slave, answer in the second access cycle after setup
  wire accessNow = psel & penable & ~pready_reg;
  wire wrNow     = accessNow & pwrite;
  wire rdNow     = accessNow & ~pwrite;
  wire selCtl    = (paddr == `TPOS_OFS_CONTROL);
  wire selSta    = (paddr == `TPOS_OFS_STATUS);
  wire selPer    = (paddr == `TPOS_OFS_PERIOD);
  wire selCfg    = (paddr == `TPOS_OFS_CHOPCFG);
  wire selD0     = (paddr == `TPOS_OFS_DUTY0);
  wire selD1     = (paddr == `TPOS_OFS_DUTY1);
  wire selD2     = (paddr == `TPOS_OFS_DUTY2);
  wire selEn     = (paddr == `TPOS_OFS_OUTEN);
  wire mapped    = selCtl | selSta | selPer | selCfg | selD0 | selD1 | selD2 | selEn;
  wire [3:0] reloadHit = {selD2, selD1, selD0, selPer} & {4{wrNow}};

  // sync rising edge, suppressed while tripped
  wire syncRise = cycleSyncIn & ~syncPrev_reg & ~tripLow;
  wire [31:0] statusWord = {22'h00_0000, syncIrqFlag_reg, tripIrqFlag_reg,
                            4'h0, tripLevel_reg, 2'b00, ~timingRun_reg & 1'b0};

  logic [31:0] readMux;
  always_comb begin
    readMux = 32'h0000_0000;
    if (selCtl) readMux = {24'h00_0000, mainControl_reg};
    if (selSta) readMux = statusWord;
    if (selPer) readMux = {16'h0000, periodRegister_reg};
    if (selCfg) readMux = {16'h0000, gateChopConfig_reg};
    if (selD0)  readMux = {16'h0000, dutyPhase0_reg};
    if (selD1)  readMux = {16'h0000, dutyPhase1_reg};
    if (selD2)  readMux = {16'h0000, dutyPhase2_reg};
    if (selEn)  readMux = {23'h00_0000, outenShadow_reg};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= psel & penable & ~pready_reg;
      pslverr_reg <= accessNow & ~mapped;
      prdata_reg  <= rdNow ? readMux : 32'h0000_0000;
    end
  end

  // software registers; shadow of output enable loaded by writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outenShadow_reg    <= `TPOS_OUTEN_RST;
      gateChopConfig_reg <= `TPOS_CHOPCFG_RST;
      periodRegister_reg <= 16'h0000;
      dutyPhase0_reg     <= 16'h0000;
      dutyPhase1_reg     <= 16'h0000;
      dutyPhase2_reg     <= 16'h0000;
    end else if (wrNow) begin
      if (selEn)  outenShadow_reg    <= pwdata[8:0];
      if (selCfg) gateChopConfig_reg <= pwdata[15:0];
      if (selPer) periodRegister_reg <= pwdata[15:0];
      if (selD0)  dutyPhase0_reg     <= pwdata[15:0];
      if (selD1)  dutyPhase1_reg     <= pwdata[15:0];
      if (selD2)  dutyPhase2_reg     <= pwdata[15:0];
    end
  end

  // active output-enable register only moves at a sync rising edge;
  // the sync source owns single or double update rate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outputEnableCrossover_reg <= `TPOS_OUTEN_RST;
      syncPrev_reg              <= 1'b0;
    end else begin
      syncPrev_reg <= cycleSyncIn;
      if (syncRise) begin
        outputEnableCrossover_reg <= outenShadow_reg;
      end
    end
  end

  // main control: trip clears the global enable, trip wins over writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mainControl_reg <= 8'h00;
    end else if (tripEntered) begin
      mainControl_reg[`TPOS_CTL_ENABLE] <= 1'b0;
    end else if (wrNow & selCtl) begin
      mainControl_reg <= pwdata[7:0];
    end
  end

  // flags: write one clears, a new event wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tripIrqFlag_reg <= 1'b0;
      syncIrqFlag_reg <= 1'b0;
    end else begin
      tripIrqFlag_reg <= tripEntered |
        (tripIrqFlag_reg & ~(wrNow & selSta & pwdata[`TPOS_STA_TRIPIRQ]));
      syncIrqFlag_reg <= syncRise |
        (syncIrqFlag_reg & ~(wrNow & selSta & pwdata[`TPOS_STA_SYNCIRQ]));
    end
  end

  // timing run: halted by trip, resumes after all four reloads and trip high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reloadSeen_reg <= 4'h0;
      timingRun_reg  <= 1'b0;
    end else if (tripLow) begin
      timingRun_reg  <= 1'b0;
      reloadSeen_reg <= (timingRun_reg ? 4'h0 : reloadSeen_reg) | reloadHit;
    end else begin
      reloadSeen_reg <= reloadSeen_reg | reloadHit;
      if ((reloadSeen_reg | reloadHit) == `TPOS_WRITES_ALL) begin
        timingRun_reg <= 1'b1;
      end
    end
  end

  // interrupt lines: trip as normal irq, sync as fast irq only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tripIrq_reg <= 1'b0;
      syncFiq_reg <= 1'b0;
    end else begin
      tripIrq_reg <= tripIrqFlag_reg;
      syncFiq_reg <= syncIrqFlag_reg;
    end
  end

  // gate path: crossover, then disable, then chop
  logic chopCarrier;
  tpos_chop_carrier #(
    .DIV_W(8)
  ) uCarrier (
    .clk    (clk),
    .rst    (rst),
    .divider(gateChopConfig_reg[7:0]),
    .carrier(chopCarrier)
  );
  wire chopHigh = gateChopConfig_reg[`TPOS_CHOP_HI_BIT];
  wire chopLow  = gateChopConfig_reg[`TPOS_CHOP_LO_BIT];
  tpos_gates_t swapped;
  tpos_gates_t enabled;
  tpos_gates_t chopped;
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : gPhase
      // phase p swap bit is 8-p; disable bits: high 4-2p, low 5-2p
      wire swapOn = outputEnableCrossover_reg[`TPOS_XOVR_LSB + 2 - p];
      assign swapped.high[p] = swapOn ? timingGates.low[p]  : timingGates.high[p];
      assign swapped.low[p]  = swapOn ? timingGates.high[p] : timingGates.low[p];
      assign enabled.high[p] = swapped.high[p] & ~outputEnableCrossover_reg[4-2*p];
      assign enabled.low[p]  = swapped.low[p]  & ~outputEnableCrossover_reg[5-2*p];
      assign chopped.high[p] = enabled.high[p] & (~chopHigh | chopCarrier);
      assign chopped.low[p]  = enabled.low[p]  & (~chopLow  | chopCarrier);
    end
  endgenerate

  // trip pin clears the gate flops directly, no clock needed
  wire gateClear = rst | ~faultTripN;
  always_ff @(posedge clk or posedge gateClear) begin
    if (gateClear) begin
      gateOut_reg <= '0;
    end else begin
      gateOut_reg <= chopped;
    end
  end

  // sync output is held clear by the pin itself: the filtered trip level
  // lags the pin by a few clocks, too late to stop a pulse already on its way
  always_ff @(posedge clk or posedge gateClear) begin
    if (gateClear) begin
      syncOut_reg <= 1'b0;
    end else begin
      syncOut_reg <= cycleSyncIn & ~tripLow;
    end
  end

  assign gateOut        = gateOut_reg;
  assign cycleSyncPulse = syncOut_reg;
  assign tripIrq        = tripIrq_reg;
  assign syncFiq        = syncFiq_reg;
  assign timingRun      = timingRun_reg;
  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;

  // checks
  AST_TRIP_LOW: assert property (@(posedge clk) disable iff (rst)
    !faultTripN |-> gateOut == '0) else $error("gate high during trip");
  AST_SYNC_MUTE: assert property (@(posedge clk) disable iff (rst)
    tripLow |=> !cycleSyncPulse) else $error("sync during trip");
  AST_SYNC_PIN: assert property (@(posedge clk) disable iff (rst)
    !faultTripN |-> !cycleSyncPulse) else $error("sync while trip pin low");
  AST_OUTEN_HOLD: assert property (@(posedge clk) disable iff (rst)
    !syncRise |=> $stable(outputEnableCrossover_reg)) else $error("enable moved off sync");
  AST_OUTEN_LOAD: assert property (@(posedge clk) disable iff (rst)
    syncRise |=> outputEnableCrossover_reg == $past(outenShadow_reg))
    else $error("enable not loaded on sync");
  AST_DISABLE: assert property (@(posedge clk) disable iff (rst)
    outputEnableCrossover_reg[0] |=> !gateOut.high[2]) else $error("2H not disabled");
  AST_DIS_LOW0: assert property (@(posedge clk) disable iff (rst)
    outputEnableCrossover_reg[5] |=> !gateOut.low[0]) else $error("0L not disabled");
  AST_TRIP_FLAG: assert property (@(posedge clk) disable iff (rst)
    tripEntered |=> tripIrqFlag_reg ##1 tripIrq) else $error("trip flag missing");
  AST_SYNC_FLAG: assert property (@(posedge clk) disable iff (rst)
    syncRise |=> syncIrqFlag_reg ##1 syncFiq) else $error("sync flag missing");
  AST_EN_CLEAR: assert property (@(posedge clk) disable iff (rst)
    tripEntered |=> !mainControl_reg[`TPOS_CTL_ENABLE]) else $error("enable not cleared");
  AST_FLAG_W1C: assert property (@(posedge clk) disable iff (rst)
    wrNow && selSta && pwdata[`TPOS_STA_SYNCIRQ] && !syncRise |=> !syncIrqFlag_reg)
    else $error("sync flag not cleared");
  AST_RUN_HALT: assert property (@(posedge clk) disable iff (rst)
    tripLow |=> !timingRun) else $error("timing ran in trip");
  AST_SWAP: assert property (@(posedge clk) disable iff (rst)
    faultTripN && outputEnableCrossover_reg[8] && outputEnableCrossover_reg[5:4] == 2'b00
    && gateChopConfig_reg[9:8] == 2'b00 |=> gateOut.low[0] == $past(timingGates.high[0])
    || !faultTripN) else $error("swap wrong");
  AST_XOVR_P2: assert property (@(posedge clk) disable iff (rst)
    faultTripN && outputEnableCrossover_reg[6] && outputEnableCrossover_reg[1:0] == 2'b00
    && gateChopConfig_reg[9:8] == 2'b00 |=> gateOut.high[2] == $past(timingGates.low[2])
    || !faultTripN) else $error("pair 2 swap wrong");
  AST_CHOP_HI: assert property (@(posedge clk) disable iff (rst)
    chopHigh && !chopCarrier |=> gateOut.high == 3'b000) else $error("high side not chopped");
  AST_CHOP_LO: assert property (@(posedge clk) disable iff (rst)
    chopLow && !chopCarrier |=> gateOut.low == 3'b000) else $error("low side not chopped");
  COV_TRIP: cover property (@(posedge clk) disable iff (rst) tripEntered);
  COV_SYNC: cover property (@(posedge clk) disable iff (rst) syncRise);
  COV_RUN: cover property (@(posedge clk) disable iff (rst) $rose(timingRun_reg));
  COV_CHOP_HI: cover property (@(posedge clk) disable iff (rst) chopHigh && chopCarrier);
  COV_SWAP: cover property (@(posedge clk) disable iff (rst)
    faultTripN && outputEnableCrossover_reg[8]);
endmodule
`default_nettype wire

//--- tpos_consts.svh
// Purpose: constants of the three-phase pwm output stage
// Assumes: apb byte addresses, 32-bit data
// Notes:   definitions only
`ifndef TPOS_CONSTS_SVH
`define TPOS_CONSTS_SVH
`define TPOS_ADDR_W        12
`define TPOS_OFS_CONTROL   12'h000
`define TPOS_OFS_STATUS    12'h004
`define TPOS_OFS_PERIOD    12'h008
`define TPOS_OFS_CHOPCFG   12'h010
`define TPOS_OFS_DUTY0     12'h014
`define TPOS_OFS_DUTY1     12'h018
`define TPOS_OFS_DUTY2     12'h01C
`define TPOS_OFS_OUTEN     12'h020
`define TPOS_OUTEN_RST     9'h000
`define TPOS_CHOPCFG_RST   16'h0000
`define TPOS_CHOP_HI_BIT   8
`define TPOS_CHOP_LO_BIT   9
`define TPOS_XOVR_LSB      6
`define TPOS_STA_TRIPRAW   3
`define TPOS_STA_TRIPIRQ   8
`define TPOS_STA_SYNCIRQ   9
`define TPOS_CTL_ENABLE    0
`define TPOS_CTL_DOUBLE    2
`define TPOS_CHOP_QUARTER  2
`define TPOS_WRITES_ALL    4'hF
`endif

//--- tpos_pkg.sv
// Purpose: types of the three-phase pwm output stage
// Assumes: six gate signals, three phase pairs
// Notes:   index 0 of each side is phase 0
package tpos_pkg;
  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } tpos_gates_t;
endpackage

//--- tpos_chop_carrier.sv
// Purpose: square chopping carrier of period 4*(div+1) clocks
// Assumes: divider held steady while running
// Notes:   half high, half low
`timescale 1ns/1ps
`default_nettype none
`include "tpos_consts.svh"
module tpos_chop_carrier #(
  parameter int DIV_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [DIV_W-1:0] divider,
  output var  logic             carrier
);
  // count to 2*(div+1)-1 then toggle: full period is 4*(div+1)
  localparam int CNT_W = DIV_W + 2;
  logic [CNT_W-1:0] countReg;
  logic             carrierReg;
  wire  [CNT_W-1:0] halfLast = CNT_W'(({2'b00, divider} + 1'b1) << 1) - 1'b1;
  wire              wrapNow  = (countReg >= halfLast);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      countReg   <= '0;
      carrierReg <= 1'b0;
    end else if (wrapNow) begin
      countReg   <= '0;
      carrierReg <= ~carrierReg;
    end else begin
      countReg   <= countReg + 1'b1;
    end
  end
  assign carrier = carrierReg;
endmodule
`default_nettype wire

//--- tpos_far_model.sv
// Purpose: far side of the stage: timing unit gates, sync source, trip pin
// Assumes: same clock as the stage, all changes right after a rising edge
// Notes:   the trip pin idles high; the bench drives it low only to trip
`timescale 1ns/1ps
`default_nettype none
module tpos_far_model
  import tpos_pkg::*;
(
  input  wire logic  clk,
  output var  tpos_gates_t timingGates,
  output var  logic  cycleSyncIn,
  output var  logic  faultTripN
);
  initial begin
    timingGates = '0;
    cycleSyncIn = 1'b0;
    faultTripN  = 1'b1;
  end
  task automatic setGates(input tpos_gates_t g);
    @(posedge clk);
    timingGates <= g;
  endtask
  // one-cycle pulse; the stage acts on its rising edge
  task automatic syncPulse();
    @(posedge clk);
    cycleSyncIn <= 1'b1;
    @(posedge clk);
    cycleSyncIn <= 1'b0;
  endtask
  task automatic setTrip(input logic level);
    @(posedge clk);
    faultTripN <= level;
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Purpose: self-checking bench of the three-phase pwm output stage
// Assumes: apb with one wait state, far side from tpos_far_model
// Notes:   expected gates are worked out here, never read back from the design
`timescale 1ns/1ps
`default_nettype none
`include "tpos_consts.svh"
module tb_top
  import tpos_pkg::*;
;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  tpos_gates_t timingGates, gateOut;
  logic        cycleSyncIn, faultTripN, cycleSyncPulse, tripIrq, syncFiq, timingRun;
  int          mismatches, checks_done, syncSeen;

  initial clk = 1'b0;
  always #50 clk = ~clk;
  always @(posedge clk) if (cycleSyncPulse === 1'b1) syncSeen++;

  tpos_output_stage i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .timingGates, .cycleSyncIn, .faultTripN, .gateOut,
    .cycleSyncPulse, .tripIrq, .syncFiq, .timingRun);
  tpos_far_model far (.clk, .timingGates, .cycleSyncIn, .faultTripN);

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask
  // request held until pready is sampled high; no cycle count assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge clk);
    if (n >= 20) begin
      mismatches++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rdChk(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
    chk({31'h0000_0000, err}, {31'h0000_0000, ee});
  endtask
  task automatic writeTiming();
    apb(1'b1, `TPOS_OFS_PERIOD, 32'h0000_0064);
    apb(1'b1, `TPOS_OFS_DUTY0, 32'h0000_0020);
    apb(1'b1, `TPOS_OFS_DUTY1, 32'h0000_0020);
    apb(1'b1, `TPOS_OFS_DUTY2, 32'h0000_0010);
  endtask
  function automatic tpos_gates_t expGate(input tpos_gates_t t, input logic [8:0] en);
    tpos_gates_t r;
    for (int p = 0; p < 3; p++) begin
      r.high[p] = (en[8-p] ? t.low[p] : t.high[p]) & ~en[4-2*p];
      r.low[p]  = (en[8-p] ? t.high[p] : t.low[p]) & ~en[5-2*p];
    end
    return r;
  endfunction

  task automatic tReset();
    rdChk(`TPOS_OFS_OUTEN, 32'h0000_0000, 1'b0);
    rdChk(`TPOS_OFS_CHOPCFG, 32'h0000_0000, 1'b0);
    rdChk(12'h0FC, 32'h0000_0000, 1'b1); // unmapped place is refused
  endtask
  task automatic tXover();
    logic [8:0]  vals [5] = '{9'h1C0, 9'h003, 9'h0A7, 9'h03F, 9'h000};
    tpos_gates_t g [2] = '{6'h2A, 6'h15};
    logic [8:0]  act = 9'h000;
    foreach (vals[i]) begin
      apb(1'b1, `TPOS_OFS_OUTEN, {23'h00_0000, vals[i]});
      foreach (g[j]) begin
        far.setGates(g[j]);
        repeat (3) @(posedge clk);
        chk(32'(gateOut), 32'(expGate(g[j], act)));
      end
      far.syncPulse();
      act = vals[i];
      foreach (g[j]) begin
        far.setGates(g[j]);
        repeat (3) @(posedge clk);
        chk(32'(gateOut), 32'(expGate(g[j], act)));
      end
    end
  endtask
  task automatic tSync();
    int n = syncSeen;
    far.syncPulse();
    repeat (4) @(posedge clk);
    chk(32'(syncSeen - n), 32'h0000_0001);
    chk({31'h0000_0000, syncFiq}, 32'h0000_0001);
    apb(1'b0, `TPOS_OFS_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0308, 32'h0000_0208);
    apb(1'b1, `TPOS_OFS_STATUS, 32'h0000_0200);
    apb(1'b0, `TPOS_OFS_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0308, 32'h0000_0008);
    chk({31'h0000_0000, syncFiq}, 32'h0000_0000);
  endtask
  // chop is set while timing is idle, as software must
  task automatic tChop();
    logic [31:0] cfg [4] = '{32'h0000_0100, 32'h0000_0102, 32'h0000_0203, 32'h0000_0100};
    int p, h, l;
    far.setGates(6'h3F);
    foreach (cfg[k]) begin
      if (k == 3) begin
        apb(1'b1, `TPOS_OFS_OUTEN, 32'h0000_0010);
        far.syncPulse();
      end
      apb(1'b1, `TPOS_OFS_CHOPCFG, cfg[k]);
      p = 4 * (cfg[k][7:0] + 1);
      repeat (2 * p) @(posedge clk);
      h = 0;
      l = 0;
      for (int c = 0; c < 2 * p; c++) begin
        @(posedge clk);
        h += (k == 3) ? gateOut.high[0] : gateOut.high[1];
        l += gateOut.low[0];
      end
      chk(h, (k == 3) ? 0 : (cfg[k][8] ? p : 2 * p));
      chk(l, cfg[k][9] ? p : 2 * p);
    end
    apb(1'b1, `TPOS_OFS_CHOPCFG, 32'h0000_0000);
    apb(1'b1, `TPOS_OFS_OUTEN, 32'h0000_0000);
    far.syncPulse();
  endtask
  task automatic tTrip();
    int n;
    apb(1'b1, `TPOS_OFS_CONTROL, 32'h0000_0001);
    writeTiming();
    repeat (2) @(posedge clk);
    chk({31'h0000_0000, timingRun}, 32'h0000_0001);
    far.setTrip(1'b0);
    #1;
    chk(32'(gateOut), 32'h0000_0000);
    n = syncSeen;
    far.syncPulse();
    repeat (6) @(posedge clk);
    chk(32'(syncSeen - n), 32'h0000_0000);
    chk({30'h0000_0000, tripIrq, timingRun}, 32'h0000_0002);
    chk(32'(gateOut), 32'h0000_0000);
    apb(1'b0, `TPOS_OFS_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0108, 32'h0000_0100);
    rdChk(`TPOS_OFS_CONTROL, 32'h0000_0000, 1'b0);
    far.setTrip(1'b1);
    repeat (6) @(posedge clk);
    chk({31'h0000_0000, timingRun}, 32'h0000_0000);
    apb(1'b1, `TPOS_OFS_STATUS, 32'h0000_0100);
    apb(1'b0, `TPOS_OFS_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0108, 32'h0000_0008);
    chk({31'h0000_0000, tripIrq}, 32'h0000_0000);
    writeTiming();
    repeat (2) @(posedge clk);
    chk({31'h0000_0000, timingRun}, 32'h0000_0001);
  endtask

  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000;
    mismatches = 0; checks_done = 0; syncSeen = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    tReset();
    tXover();
    tSync();
    tChop();
    tTrip();
    test_done();
  end
endmodule
`default_nettype wire
